// [rtl/dcm_top.sv]
// Purpose: Debug comparator match qualifier with Wishbone registers
// Assumes: One clock; monitored bus signals are on the same clock
// Notes:   Comparators 0 and 2 qualify data, 1 and 3 qualify size
//
// What this block does
// - Size disabled: match like data comparators
// - Size enabled: match only selected width
// - Byte setting rejects covering word access
// - Enable set, select clear: words only
// - Enable set, select set: bytes only
// - Otherwise byte and word both match
// - Word at address minus one never matches
// - Data comparison ignores access size
// - Masked data bits are don't care
// - Sense bit picks equal or differ
// - Equal mode, all masked: address only
// - Differ mode, all masked: never matches
//
// Implementation choices: the Wishbone register port and the register offsets.

`timescale 1ns/1ps

module dcm_top #(
   parameter int unsigned AW   = dcm_pkg::ADDR_W,
   parameter int unsigned DW   = dcm_pkg::DATA_W,
   parameter int unsigned NCMP = dcm_pkg::NCMP
) (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // Wishbone slave
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   // Monitored CPU access
   input  wire logic            acc_valid_i,
   input  wire logic [AW-1:0]   acc_addr_i,
   input  wire logic            acc_byte_i,
   input  wire logic [DW-1:0]   acc_data_i,
   // Results
   output logic      [NCMP-1:0] match_o,
   output logic                 irq_o
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [dcm_pkg::CTRL_W-1:0] ctrl_q [NCMP];
   logic [AW-1:0]              addr_q [NCMP];
   logic [DW-1:0]              dval_q [2];
   logic [DW-1:0]              dmsk_q [2];
   logic [NCMP-1:0]            stat_q;
   logic [NCMP-1:0]            en_q;
   logic [NCMP-1:0]            match_q;
   logic                       irq_q;
   logic                       ack_q;
   logic [31:0]                rdat_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic        req;
   wire logic        wr;
   wire logic        rd;
   wire logic [31:0] wmask;
   wire logic        hit_clr;
   wire logic        hit_en;

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   assign req     = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr      = req && wb_we_i;
   assign rd      = req && !wb_we_i;
   assign wmask   = lane_mask(wb_sel_i);
   assign hit_clr = wr && (wb_adr_i == dcm_pkg::OFS_IRQ_CLR);
   assign hit_en  = wr && (wb_adr_i == dcm_pkg::OFS_IRQ_EN);

   // ----------------------------------------------------------------
   // Comparators
   // ----------------------------------------------------------------
   wire logic [NCMP-1:0] hit;

   genvar gi;
   generate
      for (gi = 0; gi < NCMP; gi++) begin : g_cmp
         localparam bit IS_DATA = ((gi % 2) == 0);
         localparam int DI      = (gi / 2) % 2;
         localparam logic [7:0] OFS_C = dcm_pkg::OFS_CTRL0 + 8'(4 * gi);
         localparam logic [7:0] OFS_A = dcm_pkg::OFS_ADDR0 + 8'(4 * gi);
         wire logic [31:0] c_new;
         wire logic [31:0] a_new;

         assign c_new = merge(32'(ctrl_q[gi]), wb_dat_i, wmask);
         assign a_new = merge(32'(addr_q[gi]), wb_dat_i, wmask);

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               ctrl_q[gi] <= dcm_pkg::CTRL_RST;
               addr_q[gi] <= dcm_pkg::ADDR_RST;
            end else if (wr && wb_adr_i == OFS_C) begin
               ctrl_q[gi] <= c_new[dcm_pkg::CTRL_W-1:0];
            end else if (wr && wb_adr_i == OFS_A) begin
               addr_q[gi] <= a_new[AW-1:0];
            end
         end

         dcm_cmp #(
            .AW       (AW),
            .DW       (DW),
            .HAS_DATA (IS_DATA),
            .HAS_SIZE (!IS_DATA)
         ) u_cmp (
            .enable_i                 (ctrl_q[gi][dcm_pkg::CTRL_ENABLE_BIT]),
            .size_compare_enable_i    (ctrl_q[gi][dcm_pkg::CTRL_SZE_BIT]),
            .access_width_select_bit_i(ctrl_q[gi][dcm_pkg::CTRL_WIDTH_BIT]),
            .data_mismatch_select_i   (ctrl_q[gi][dcm_pkg::CTRL_MISMATCH_BIT]),
            .cmp_addr_i               (addr_q[gi]),
            .cmp_data_i               (dval_q[DI]),
            .data_mask_i              (dmsk_q[DI]),
            .acc_valid_i              (acc_valid_i),
            .acc_addr_i               (acc_addr_i),
            .acc_byte_i               (acc_byte_i),
            .acc_data_i               (acc_data_i),
            .match_o                  (hit[gi])
         );
      end

      for (gi = 0; gi < 2; gi++) begin : g_data
         localparam logic [7:0] OFS_D = dcm_pkg::OFS_DATA0 + 8'(4 * gi);
         wire logic [31:0] d_new;

         assign d_new = merge({dmsk_q[gi], dval_q[gi]}, wb_dat_i, wmask);

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               dval_q[gi] <= dcm_pkg::DVAL_RST;
               dmsk_q[gi] <= dcm_pkg::DMSK_RST;
            end else if (wr && wb_adr_i == OFS_D) begin
               dval_q[gi] <= d_new[dcm_pkg::DREG_VAL_LSB +: DW];
               dmsk_q[gi] <= d_new[dcm_pkg::DREG_MASK_LSB +: DW];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   logic [31:0] rmux;

   always_comb begin
      rmux = 32'h00000000;
      for (int i = 0; i < NCMP; i++) begin
         if (wb_adr_i == dcm_pkg::OFS_CTRL0 + 8'(4 * i)) begin
            rmux = 32'(ctrl_q[i]);
         end
         if (wb_adr_i == dcm_pkg::OFS_ADDR0 + 8'(4 * i)) begin
            rmux = 32'(addr_q[i]);
         end
      end
      if (wb_adr_i == dcm_pkg::OFS_DATA0) begin
         rmux = {dmsk_q[0], dval_q[0]};
      end
      if (wb_adr_i == dcm_pkg::OFS_DATA2) begin
         rmux = {dmsk_q[1], dval_q[1]};
      end
      if (wb_adr_i == dcm_pkg::OFS_IRQ_STAT) begin
         rmux = 32'(stat_q);
      end
      if (wb_adr_i == dcm_pkg::OFS_IRQ_EN) begin
         rmux = 32'(en_q);
      end
   end

   // ----------------------------------------------------------------
   // Bus answer, match and interrupt
   // ----------------------------------------------------------------
   wire logic [NCMP-1:0] stat_d;
   wire logic [NCMP-1:0] clr_bits;

   assign clr_bits = hit_clr ? wb_dat_i[NCMP-1:0] & wmask[NCMP-1:0]
                             : '0;
   // Set wins over a clear in the same cycle
   assign stat_d = (stat_q & ~clr_bits) | hit;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdat_q  <= 32'h00000000;
         match_q <= '0;
         stat_q  <= dcm_pkg::IRQ_RST;
         en_q    <= dcm_pkg::IRQ_RST;
         irq_q   <= 1'b0;
      end else begin
         ack_q   <= req;
         rdat_q  <= rd ? rmux : 32'h00000000;
         match_q <= hit;
         stat_q  <= stat_d;
         if (hit_en) begin
            en_q <= (en_q & ~wmask[NCMP-1:0]) |
                    (wb_dat_i[NCMP-1:0] & wmask[NCMP-1:0]);
         end
         irq_q   <= |(stat_d & (hit_en ?
                    ((en_q & ~wmask[NCMP-1:0]) |
                     (wb_dat_i[NCMP-1:0] & wmask[NCMP-1:0])) : en_q));
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign match_o  = match_q;
   assign irq_o    = irq_q;

endmodule : dcm_top

// [rtl/dcm_pkg.sv]
// Purpose: Shared constants for the debug comparator match qualifier
// Assumes: 32-bit classic Wishbone register bus, 16-bit monitored data
// Notes:   Register offsets are byte addresses of aligned words

package dcm_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 23;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned NCMP   = 4;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CTRL2 = 8'h08;
   localparam logic [7:0] OFS_CTRL3 = 8'h0c;
   localparam logic [7:0] OFS_ADDR0 = 8'h10;
   localparam logic [7:0] OFS_ADDR1 = 8'h14;
   localparam logic [7:0] OFS_ADDR2 = 8'h18;
   localparam logic [7:0] OFS_ADDR3 = 8'h1c;
   localparam logic [7:0] OFS_DATA0 = 8'h20;
   localparam logic [7:0] OFS_DATA2 = 8'h24;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h34;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h38;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_ENABLE_BIT   = 0;
   localparam int unsigned CTRL_SZE_BIT      = 1;
   localparam int unsigned CTRL_WIDTH_BIT    = 2;
   localparam int unsigned CTRL_MISMATCH_BIT = 3;
   localparam int unsigned CTRL_W            = 4;

   // Data register: value low half, mask high half
   localparam int unsigned DREG_VAL_LSB  = 0;
   localparam int unsigned DREG_MASK_LSB = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
   localparam logic [DATA_W-1:0] DVAL_RST = 16'h0000;
   localparam logic [DATA_W-1:0] DMSK_RST = 16'h0000;
   localparam logic [NCMP-1:0]   IRQ_RST  = 4'h0;

endpackage : dcm_pkg

// [rtl/dcm_cmp.sv]
// Purpose: One address comparator with optional size and data qualify
// Assumes: Access presented for one cycle with valid strobe
// Notes:   Purely combinational; the caller registers the result

`timescale 1ns/1ps

module dcm_cmp #(
   parameter int unsigned AW       = 23,
   parameter int unsigned DW       = 16,
   parameter bit          HAS_DATA = 1'b1,
   parameter bit          HAS_SIZE = 1'b0
) (
   input  wire logic          enable_i,
   input  wire logic          size_compare_enable_i,
   input  wire logic          access_width_select_bit_i,
   input  wire logic          data_mismatch_select_i,
   input  wire logic [AW-1:0] cmp_addr_i,
   input  wire logic [DW-1:0] cmp_data_i,
   input  wire logic [DW-1:0] data_mask_i,
   input  wire logic          acc_valid_i,
   input  wire logic [AW-1:0] acc_addr_i,
   input  wire logic          acc_byte_i,
   input  wire logic [DW-1:0] acc_data_i,
   output logic               match_o
);

   // ----------------------------------------------------------------
   // Qualifiers
   // ----------------------------------------------------------------
   wire logic          addr_eq;
   wire logic          size_ok;
   wire logic          data_ok;
   wire logic [DW-1:0] diff_bits;
   wire logic          any_diff;
   wire logic          width_hit;

   assign addr_eq = (acc_addr_i == cmp_addr_i);

   assign diff_bits = (acc_data_i ^ cmp_data_i) & data_mask_i;
   assign any_diff  = |diff_bits;

   assign width_hit = (acc_byte_i == access_width_select_bit_i);

   assign size_ok = !HAS_SIZE || !size_compare_enable_i || width_hit;

   assign data_ok = !HAS_DATA ||
                    (data_mismatch_select_i ? any_diff : !any_diff);

   assign match_o = enable_i && acc_valid_i && addr_eq && size_ok &&
                    data_ok;

endmodule : dcm_cmp

// [tb/dcm_cpu.sv]
// Purpose: Monitored CPU access source for the comparator block
// Assumes: One single-cycle access per call, same clock as the block
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ps
module dcm_cpu (
   input  wire logic        clk_i,
   output logic             valid_o,
   output logic [22:0]      addr_o,
   output logic             byte_o,
   output logic [15:0]      data_o
);
   initial begin
      valid_o = 1'b0;
      addr_o  = 23'h000000;
      byte_o  = 1'b0;
      data_o  = 16'h0000;
   end
   task automatic issue(input logic [22:0] a, input logic b,
                        input logic [15:0] d);
      @(posedge clk_i);
      valid_o <= 1'b1;
      addr_o  <= a;
      byte_o  <= b;
      data_o  <= d;
      @(posedge clk_i);
      valid_o <= 1'b0;
      addr_o  <= ~a;
      data_o  <= ~d;
   endtask : issue
endmodule : dcm_cpu

// [tb/dcm_chk_sva.sv]
// Purpose: Port-level checks of the comparator block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Shadows the interrupt enable from bus writes
`timescale 1ns/1ps
module dcm_chk #(
   parameter int unsigned NCMP = 4
) (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   input  wire logic [31:0]     wb_dat_o,
   input  wire logic            wb_ack_o,
   input  wire logic            acc_valid_i,
   input  wire logic [NCMP-1:0] match_o,
   input  wire logic            irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [NCMP-1:0] en_q;
   logic [NCMP-1:0] en_d;
   logic            en_wr;
   logic            wr_req;
   assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
   assign en_wr  = wr_req && !wb_ack_o && wb_sel_i[0]
                   && wb_adr_i == dcm_pkg::OFS_IRQ_EN;
   assign en_d   = en_wr ? wb_dat_i[NCMP-1:0] : en_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= '0;
      end else begin
         en_q <= en_d;
      end
   end
   match_cause_a: assert property (match_o != '0 |-> $past(acc_valid_i))
      else $error("match without access");
   match_pulse_a: assert property (!acc_valid_i |=> match_o == '0)
      else $error("match outside access cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("read data outside ack");
   irq_match_a: assert property ((match_o & en_q) != '0 |-> irq_o)
      else $error("enabled match without irq");
   irq_hold_a: assert property (irq_o && !wr_req |=> irq_o)
      else $error("irq dropped without write");
   reset_quiet_a: assert property (disable iff (1'b0)
      rst_i |=> match_o == '0 && !irq_o && !wb_ack_o)
      else $error("outputs active after reset");
   cover property (match_o[1]);
   cover property (match_o[0]);
   cover property ($rose(irq_o));
   cover property (wb_ack_o && !wb_we_i);
endmodule : dcm_chk
bind dcm_top dcm_chk #(.NCMP(NCMP)) dcm_chk_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .acc_valid_i(acc_valid_i), .match_o(match_o), .irq_o(irq_o));

// [tb/tb_dcm_top.sv]
// Purpose: Self-checking bench of the comparator block
// Assumes: Comparators 0 and 1 share one programmed address
// Notes:   Table rows hold control, data and access with match
`timescale 1ns/1ps
module tb_dcm_top;
   typedef struct packed {
      logic [3:0]  c0;
      logic [31:0] d0;
      logic [3:0]  c1;
      logic [22:0] a;
      logic        b;
      logic [15:0] dt;
      logic [3:0]  ex;
   } dcm_row_t;
   localparam logic [22:0] A = 23'h012344;
   localparam logic [22:0] B = 23'h012343;
   dcm_row_t rows [9] = '{
      '{4'h1, 32'h0, 4'h1, A, 1'b0, 16'h5555, 4'h3},
      '{4'h1, 32'h0, 4'h1, A, 1'b1, 16'h5555, 4'h3},
      '{4'h9, 32'h0, 4'h3, A, 1'b0, 16'h5555, 4'h2},
      '{4'h1, 32'h00ff00ab, 4'h3, A, 1'b1, 16'h00ab, 4'h1},
      '{4'h9, 32'h00ff00ab, 4'h7, A, 1'b1, 16'h12ab, 4'h2},
      '{4'h9, 32'h00ff00ab, 4'h7, A, 1'b0, 16'h12ac, 4'h1},
      '{4'h1, 32'h0, 4'h1, B, 1'b0, 16'h0000, 4'h0},
      '{4'h1, 32'h00ff00ab, 4'h5, A, 1'b1, 16'h34ab, 4'h3},
      '{4'h1, 32'hff001200, 4'h0, A, 1'b0, 16'h12ff, 4'h1}};
   logic        clk_i  = 1'b0;
   logic        rst_i  = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we  = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [31:0] wb_wd  = 32'h0;
   logic [3:0]  wb_sel = 4'hf;
   logic [3:0]  sel_v  = 4'hf;
   logic [31:0] wb_rd;
   logic        wb_ack;
   logic        av;
   logic [22:0] aa;
   logic        ab;
   logic [15:0] ad;
   logic [3:0]  match;
   logic        irq;
   logic [31:0] q;
   int          mismatches = 0;
   int          checks = 0;
   int          cyc_cnt = 0;
   always #2 clk_i = ~clk_i;
   dcm_cpu dcm_cpu_inst (.clk_i(clk_i), .valid_o(av), .addr_o(aa),
      .byte_o(ab), .data_o(ad));
   dcm_top dcm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
      .wb_ack_o(wb_ack), .acc_valid_i(av), .acc_addr_i(aa),
      .acc_byte_i(ab), .acc_data_i(ad), .match_o(match), .irq_o(irq));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_sel <= sel_v;
      wb_wd  <= d;
      // Waits for wb_ack; only the bench timeout ends a wait that never sees it
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      q = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask : wb
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 16; k++) begin
         wb(1'b0, 8'(k * 4), 32'h0);
         chk("reset_read", q, 32'h0);
      end
      $display("test reset done");
      wb(1'b1, dcm_pkg::OFS_ADDR0, {9'h000, A});
      wb(1'b1, dcm_pkg::OFS_ADDR1, {9'h000, A});
      foreach (rows[i]) begin
         wb(1'b1, dcm_pkg::OFS_CTRL0, {28'h0, rows[i].c0});
         wb(1'b1, dcm_pkg::OFS_DATA0, rows[i].d0);
         wb(1'b1, dcm_pkg::OFS_CTRL1, {28'h0, rows[i].c1});
         dcm_cpu_inst.issue(rows[i].a, rows[i].b, rows[i].dt);
         #1;
         chk("match_o", {28'h0, match}, {28'h0, rows[i].ex});
      end
      $display("test table done");
      wb(1'b0, dcm_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq_stat", q, 32'h3);
      chk("irq_off", {31'h0, irq}, 32'h0);
      wb(1'b1, dcm_pkg::OFS_IRQ_EN, 32'h2);
      repeat (2) @(posedge clk_i);
      chk("irq_on", {31'h0, irq}, 32'h1);
      wb(1'b1, dcm_pkg::OFS_IRQ_CLR, 32'h2);
      repeat (2) @(posedge clk_i);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wb(1'b0, dcm_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq_left", q, 32'h1);
      wb(1'b0, dcm_pkg::OFS_IRQ_CLR, 32'h0);
      chk("irq_clr_read", q, 32'h0);
      wb(1'b1, 8'h3c, 32'hffffffff);
      wb(1'b0, 8'h3c, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("test irq done");
      sel_v = 4'h3;
      wb(1'b1, dcm_pkg::OFS_DATA2, 32'hffff1234);
      sel_v = 4'hf;
      wb(1'b0, dcm_pkg::OFS_DATA2, 32'h0);
      chk("data2_lanes", q, 32'h00001234);
      wb(1'b0, dcm_pkg::OFS_ADDR0, 32'h0);
      chk("addr0_read", q, {9'h000, A});
      wb(1'b1, dcm_pkg::OFS_ADDR2, {9'h000, A});
      wb(1'b1, dcm_pkg::OFS_ADDR3, {9'h000, A});
      wb(1'b1, dcm_pkg::OFS_CTRL2, 32'h1);
      wb(1'b1, dcm_pkg::OFS_CTRL3, 32'h7);
      wb(1'b1, dcm_pkg::OFS_IRQ_EN, 32'h4);
      chk("irq_pre", {31'h0, irq}, 32'h0);
      dcm_cpu_inst.issue(A, 1'b1, 16'h1200);
      #1;
      chk("match_hi", {28'h0, match}, 32'hd);
      chk("irq_hi", {31'h0, irq}, 32'h1);
      wb(1'b0, dcm_pkg::OFS_IRQ_STAT, 32'h0);
      chk("stat_hi", q, 32'hd);
      $display("test lanes done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, dcm_pkg::OFS_CTRL1, 32'h0);
      chk("ctrl1_rst", q, 32'h0);
      wb(1'b0, dcm_pkg::OFS_IRQ_STAT, 32'h0);
      chk("stat_rst", q, 32'h0);
      $display("test rereset done");
      report_and_stop();
   end
endmodule : tb_dcm_top
